/* hw/lvds_tx_pkg.sv */
/*
  Constants, mode type and helper functions for the differential transmitter
  channel. Assumes a single channel sits on a parallel bus of twelve 8-bit lanes.
*/
package lvds_tx_pkg;

  // ==========================================================================
  // widths and ranges
  localparam int         WORD_W      = 10;
  localparam int         FACT_W      = 4;
  localparam int         LANE_W      = 8;
  localparam int         NUM_LANE    = 12;
  localparam int         BUS_W       = 96;
  localparam int         SEL_W       = 4;
  localparam int         CFG_W       = 12;
  localparam logic [3:0] FACT_MIN    = 4'h3;
  localparam logic [3:0] FACT_MAX    = 4'hA;
  localparam logic [3:0] FACT_BYPASS = 4'h1;
  localparam logic [3:0] DIV_ONE     = 4'h1;

  // ==========================================================================
  // reset values
  localparam logic [9:0]  WORD_RST  = 10'h000;
  localparam logic [11:0] CFG_RST   = 12'h000;
  localparam logic [2:0]  PHASE_RST = 3'h0;
  localparam logic [3:0]  CNT_RST   = 4'h0;

  // ==========================================================================
  // output path modes, no codes given
  typedef enum logic [1:0] {
    MODE_SER,
    MODE_SDR,
    MODE_DDR
  } tx_mode_e;

  // ==========================================================================
  // channel n (1 based) owns bits 8n-1 down to 8n-8, else zero
  function automatic logic [7:0] lane_word(input logic [95:0] bus, input logic [3:0] n);
    int base;
    base = (int'(n) - 1) * LANE_W;
    if (n == 4'h0 || int'(n) > NUM_LANE)
      return 8'h00;
    return bus[base +: LANE_W];
  endfunction

  // legal serialization factor, three through ten
  function automatic logic fact_ok(input logic [3:0] f);
    return (f >= FACT_MIN) && (f <= FACT_MAX);
  endfunction

  // divisor of the forwarded clock must fit the word length
  function automatic logic div_ok(input logic [3:0] f, input logic [3:0] d);
    logic even_div;
    even_div = (d == 4'h2) || (d == 4'h4) || (d == 4'h6) || (d == 4'h8) || (d == 4'hA);
    return (d == DIV_ONE) || (even_div && ((f % d) == 4'h0));
  endfunction

  // place a word of f bits at the top so its msb leaves first
  function automatic logic [9:0] align_word(input logic [9:0] w, input logic [3:0] f);
    return 10'(w << (FACT_MAX - f));
  endfunction

  // clock pattern: high d/2 bits then low d/2 bits, starting at the word edge
  function automatic logic [9:0] clk_pattern(input logic [3:0] f, input logic [3:0] d,
                                             input logic inv);
    logic [9:0] pat;
    int         half;
    pat  = WORD_RST;
    half = (d > DIV_ONE) ? int'(d) / 2 : 1;
    for (int i = 0; i < WORD_W; i++) begin
      if (i < int'(f))
        pat[WORD_W - 1 - i] = (d == DIV_ONE) ? 1'b1 : (((i / half) % 2) == 0);
    end
    return inv ? (align_word(10'h3FF, f) & ~pat) : pat;
  endfunction

endpackage

/* hw/lvds_tx_serializer.sv */
/*
  One transmitter channel: word handshake on the core clock, capture and shift
  registers on the bit-rate clock, bypass paths and forwarded clock pattern.
  Assumes the bit-rate clock comes from a PLL, the configuration inputs are
  static while running, and an output cell merges the rise and fall bits.
*/
`timescale 1ns/1ps

// Function
// - accept parallel words of up to ten bits
// - most significant bit is sent first
// - capture on bit clock only under strobe
// - shift register moves one bit per cycle
// - factor three to ten, static while running
// - strobe period follows the serialization factor
// - bit clock runs at serial data rate
// - bypass gives factor two or one
// - single rate bypass carries one bit
// - double rate bypass sends two bits per cycle
// - channel n uses bus bits 8n-1:8n-8
// - channel may forward a clock instead in serial mode
// - forwarded clock may toggle at data rate
// - clock divisors 1,2,4,6,8,10 by factor
// - clock phase 0 or 180 degrees
// - finer phase in 45 degree steps
module lvds_tx_serializer (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        fast_clk_in,
  input  wire logic        word_valid_in,
  input  wire logic [9:0]  par_word_in,
  input  wire logic [95:0] lane_bus_in,
  input  wire logic [3:0]  lane_sel_in,
  input  wire logic        lane_pick_in,
  input  wire logic [3:0]  factor_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic        clk_out_en_in,
  input  wire logic [3:0]  clk_div_in,
  input  wire logic        phase_180_in,
  input  wire logic [2:0]  phase_step_in,
  output logic             word_ready_out,
  output logic             cfg_err_out,
  output logic [2:0]       pll_phase_sel_out,
  output logic             tx_rise_out,
  output logic             tx_fall_out
);

  // ==========================================================================
  // overview of the two domains
  // core side: one word per handshake, held in hold_ff until acknowledged
  // a request toggle crosses to the bit clock through two flip-flops
  // the bit clock side answers with an acknowledge toggle at a strobe
  // the acknowledge crosses back through two flip-flops to free ready
  // the hold register never changes while a request is outstanding,
  // so its ten bits may be read directly on the bit clock side
  // trade-off: a full round trip per word caps the word rate of the
  // core side; a faster core must feed words through a buffer upstream
  // latency: capture at strobe k, shifted out after strobe k+1
  // a word that misses a strobe waits for the next one; the shift
  // register then repeats the last captured word instead of idling
  // configuration is crossed bit by bit, so it must stay static;
  // a change while running can tear one word or one clock pattern
  // reset asserts in both domains at once and leaves the bit clock
  // domain two edges later, so a word offered early simply waits
  // limitation: no idle pattern exists, the far side must find the
  // word edge by its own means after reset
  // bypass modes run one word per bit clock cycle, taking the word
  // straight from the capture register to the output cell
  // the forwarded clock shares the shift register with the data path
  // ==========================================================================

  // ==========================================================================
  // core side declarations
  logic [9:0]  hold_ff;
  logic        req_tog_ff;
  logic        ack_s1_ff;
  logic        ack_s2_ff;
  logic [9:0]  nxt_word;
  logic        accept;
  logic        mode_bad;
  logic [11:0] cfg_bus;

  // ==========================================================================
  // bit clock side declarations
  logic [1:0]  rst_fast_ff;
  logic        rst_fast_b;
  logic [11:0] cfg_s1_ff;
  logic [11:0] cfg_s2_ff;
  logic        req_s1_ff;
  logic        req_s2_ff;
  logic        ack_tog_ff;
  logic [9:0]  cap_ff;
  logic [9:0]  shift_ff;
  logic        fall_src_ff;
  logic        strobe;
  logic [3:0]  f_fact;
  logic [3:0]  f_div;
  logic [3:0]  f_eff;
  logic [3:0]  f_div_eff;
  logic        f_clk_en;
  logic        f_ph180;
  logic        f_pending;
  lvds_tx_pkg::tx_mode_e f_mode;
  logic [9:0]  nxt_shift;
  logic        nxt_rise;
  logic        nxt_fall;

  // ==========================================================================
  // core side: word selection and handshake
  // the lane pick lets a channel sit on a wide multi-channel bus
  always_comb begin
    if (lane_pick_in)
      nxt_word = {2'b00, lvds_tx_pkg::lane_word(lane_bus_in, lane_sel_in)};
    else
      nxt_word = par_word_in;
  end

  assign accept = word_valid_in && word_ready_out;

  // hold register keeps the word still until the far side has it
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      hold_ff <= lvds_tx_pkg::WORD_RST;
    else if (accept)
      hold_ff <= nxt_word;
  end

  // a toggle marks each new word; level crossing keeps it safe
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      req_tog_ff <= 1'b0;
    else if (accept)
      req_tog_ff <= ~req_tog_ff;
  end

  // acknowledge toggle comes back through two flip-flops
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
    end else begin
      ack_s1_ff <= ack_tog_ff;
      ack_s2_ff <= ack_s1_ff;
    end
  end

  // ready drops on a take and returns once the word is captured
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      word_ready_out <= 1'b1;
    else if (accept)
      word_ready_out <= 1'b0;
    else if (ack_s2_ff == req_tog_ff)
      word_ready_out <= 1'b1;
  end

  // ==========================================================================
  // core side: configuration check and phase tap select
  assign mode_bad = (mode_in > 2'(lvds_tx_pkg::MODE_DDR));

  // flags a factor or divisor the channel cannot honour
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      cfg_err_out <= 1'b0;
    else
      cfg_err_out <= mode_bad
                     || ((mode_in == 2'(lvds_tx_pkg::MODE_SER)) && !lvds_tx_pkg::fact_ok(factor_in))
                     || (clk_out_en_in && !lvds_tx_pkg::div_ok(factor_in, clk_div_in));
  end

  // fine phase comes from the clock source taps, one step is 45 degrees
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      pll_phase_sel_out <= lvds_tx_pkg::PHASE_RST;
    else
      pll_phase_sel_out <= phase_step_in;
  end

  assign cfg_bus = {factor_in, mode_in, clk_div_in, clk_out_en_in, phase_180_in};

  // ==========================================================================
  // bit clock side: reset release and configuration crossing
  // reset asserts at once but leaves this domain on its own edge
  always_ff @(posedge fast_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      rst_fast_ff <= 2'b00;
    else
      rst_fast_ff <= {rst_fast_ff[0], 1'b1};
  end

  assign rst_fast_b = rst_fast_ff[1];

  // static settings only; a change while running may tear for a word
  always_ff @(posedge fast_clk_in or negedge rst_fast_b) begin
    if (!rst_fast_b) begin
      cfg_s1_ff <= lvds_tx_pkg::CFG_RST;
      cfg_s2_ff <= lvds_tx_pkg::CFG_RST;
    end else begin
      cfg_s1_ff <= cfg_bus;
      cfg_s2_ff <= cfg_s1_ff;
    end
  end

  // decode the crossed settings
  always_comb begin
    f_fact   = cfg_s2_ff[11:8];
    f_div    = cfg_s2_ff[5:2];
    f_clk_en = cfg_s2_ff[1];
    f_ph180  = cfg_s2_ff[0];
    unique case (cfg_s2_ff[7:6])
      2'(lvds_tx_pkg::MODE_SDR): f_mode = lvds_tx_pkg::MODE_SDR;
      2'(lvds_tx_pkg::MODE_DDR): f_mode = lvds_tx_pkg::MODE_DDR;
      default:                   f_mode = lvds_tx_pkg::MODE_SER;
    endcase
  end

  // bypass runs one word per bit clock; illegal factors fall back to ten
  always_comb begin
    if (f_mode != lvds_tx_pkg::MODE_SER)
      f_eff = lvds_tx_pkg::FACT_BYPASS;
    else if (lvds_tx_pkg::fact_ok(f_fact))
      f_eff = f_fact;
    else
      f_eff = lvds_tx_pkg::FACT_MAX;
    if (lvds_tx_pkg::div_ok(f_eff, f_div))
      f_div_eff = f_div;
    else
      f_div_eff = lvds_tx_pkg::DIV_ONE;
  end

  // ==========================================================================
  // bit clock side: load strobe
  tx_load_strobe u_strobe (
    .fast_clk_in (fast_clk_in),
    .rst_b_in    (rst_fast_b),
    .fact_in     (f_eff),
    .strobe_out  (strobe)
  );

  // ==========================================================================
  // bit clock side: word request crossing
  always_ff @(posedge fast_clk_in or negedge rst_fast_b) begin
    if (!rst_fast_b) begin
      req_s1_ff <= 1'b0;
      req_s2_ff <= 1'b0;
    end else begin
      req_s1_ff <= req_tog_ff;
      req_s2_ff <= req_s1_ff;
    end
  end

  assign f_pending = (req_s2_ff != ack_tog_ff);

  // answer only when the word has really been taken
  always_ff @(posedge fast_clk_in or negedge rst_fast_b) begin
    if (!rst_fast_b)
      ack_tog_ff <= 1'b0;
    else if (strobe && f_pending)
      ack_tog_ff <= req_s2_ff;
  end

  // ==========================================================================
  // bit clock side: capture register
  // hold register is quiet by the time its toggle has crossed
  // with no new word the last one repeats rather than sending junk
  always_ff @(posedge fast_clk_in or negedge rst_fast_b) begin
    if (!rst_fast_b)
      cap_ff <= lvds_tx_pkg::WORD_RST;
    else if (strobe && f_pending)
      cap_ff <= hold_ff;
  end

  // ==========================================================================
  // bit clock side: shift register
  // load at the strobe, so the next word follows the last bit directly
  always_comb begin
    if (strobe && f_clk_en)
      nxt_shift = lvds_tx_pkg::clk_pattern(f_eff, f_div_eff, f_ph180);
    else if (strobe)
      nxt_shift = lvds_tx_pkg::align_word(cap_ff, f_eff);
    else
      nxt_shift = {shift_ff[8:0], 1'b0};
  end

  // one bit per fast clock cycle
  always_ff @(posedge fast_clk_in or negedge rst_fast_b) begin
    if (!rst_fast_b)
      shift_ff <= lvds_tx_pkg::WORD_RST;
    else
      shift_ff <= nxt_shift;
  end

  // ==========================================================================
  // bit clock side: output bit selection
  // rise and fall bits leave on the two edges of the bit clock;
  // the output cell outside merges them into one pin
  // serial and single rate send the same bit on both halves
  // double rate sends bit one on the rise and bit zero on the fall
  // a clock at data rate drives the inverse on the fall half
  // the fall bit is only distinct in double rate and data rate clock
  always_comb begin
    unique case (f_mode)
      lvds_tx_pkg::MODE_SER: begin
        nxt_rise = shift_ff[lvds_tx_pkg::WORD_W - 1];
        if (f_clk_en && (f_div_eff == lvds_tx_pkg::DIV_ONE))
          nxt_fall = ~shift_ff[lvds_tx_pkg::WORD_W - 1];
        else
          nxt_fall = shift_ff[lvds_tx_pkg::WORD_W - 1];
      end
      lvds_tx_pkg::MODE_SDR: begin
        nxt_rise = cap_ff[0];
        nxt_fall = cap_ff[0];
      end
      lvds_tx_pkg::MODE_DDR: begin
        nxt_rise = cap_ff[1];
        nxt_fall = cap_ff[0];
      end
    endcase
  end

  // rising edge half of the output cell
  always_ff @(posedge fast_clk_in or negedge rst_fast_b) begin
    if (!rst_fast_b)
      tx_rise_out <= 1'b0;
    else
      tx_rise_out <= nxt_rise;
  end

  // staged so the falling edge flop reads a settled bit
  always_ff @(posedge fast_clk_in or negedge rst_fast_b) begin
    if (!rst_fast_b)
      fall_src_ff <= 1'b0;
    else
      fall_src_ff <= nxt_fall;
  end

  // falling edge half; second bit of a double rate pair
  always_ff @(negedge fast_clk_in or negedge rst_fast_b) begin
    if (!rst_fast_b)
      tx_fall_out <= 1'b0;
    else
      tx_fall_out <= fall_src_ff;
  end

endmodule

/* hw/tx_load_strobe.sv */
/*
  Load strobe generator on the bit-rate clock. Assumes the factor input is held
  static while running and the reset has already been released in this domain.
*/
`timescale 1ns/1ps
module tx_load_strobe (
  input  wire logic       fast_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic [3:0] fact_in,
  output logic            strobe_out
);

  logic [3:0] cnt_ff;
  logic [3:0] last_cnt;

  // last bit position of the current word
  assign last_cnt = (fact_in > lvds_tx_pkg::CNT_RST) ? 4'(fact_in - 4'h1) : lvds_tx_pkg::CNT_RST;

  // ==========================================================================
  // bit counter, wraps once per word period
  always_ff @(posedge fast_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      cnt_ff <= lvds_tx_pkg::CNT_RST;
    else if (cnt_ff >= last_cnt)
      cnt_ff <= lvds_tx_pkg::CNT_RST;
    else
      cnt_ff <= 4'(cnt_ff + 4'h1);
  end

  // one cycle high per word, every cycle when the factor is one
  always_ff @(posedge fast_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      strobe_out <= 1'b0;
    else
      strobe_out <= (cnt_ff >= last_cnt);
  end

endmodule

/* verif/lvds_tx_checker.sv */
/*
  Port relations of one transmitter channel: handshake, config flag, fall bit.
  Assumes a bind onto lvds_tx_serializer and configuration static between resets.
*/
`timescale 1ns/1ps
module lvds_tx_checker (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       fast_clk_in,
  input  wire logic       word_valid_in,
  input  wire logic [3:0] factor_in,
  input  wire logic [1:0] mode_in,
  input  wire logic       clk_out_en_in,
  input  wire logic [2:0] phase_step_in,
  input  wire logic       word_ready_out,
  input  wire logic       cfg_err_out,
  input  wire logic [2:0] pll_phase_sel_out,
  input  wire logic       tx_rise_out,
  input  wire logic       tx_fall_out
);
  logic [7:0] low_cnt_ff;

  // ==========================================================================
  // length of a ready-low run; a lost strobe or ack leaves it climbing
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      low_cnt_ff <= 8'h00;
    else if (word_ready_out)
      low_cnt_ff <= 8'h00;
    else
      low_cnt_ff <= low_cnt_ff + 8'h01;
  end

  // ==========================================================================
  // assertions
  ready_drop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    word_valid_in && word_ready_out |=> !word_ready_out) else $error("ready stayed high after a word");
  ready_bound_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    low_cnt_ff < 8'h3C) else $error("word never taken by a strobe");
  cfg_mode_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    mode_in == 2'h3 |=> cfg_err_out) else $error("illegal mode not flagged");
  cfg_fact_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    mode_in == 2'h0 && (factor_in < 4'h3 || factor_in > 4'hA) |=> cfg_err_out) else $error("bad factor not flagged");
  cfg_bypass_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (mode_in == 2'h1 || mode_in == 2'h2) && !clk_out_en_in |=> !cfg_err_out) else $error("bypass flagged");
  cfg_legal_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    mode_in == 2'h0 && !clk_out_en_in && factor_in >= 4'h3 && factor_in <= 4'hA |=> !cfg_err_out)
    else $error("legal factor flagged");
  phase_sel_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    phase_step_in != 3'h0 |=> pll_phase_sel_out == $past(phase_step_in)) else $error("phase tap not passed on");
  fall_follow_a: assert property (@(posedge fast_clk_in) disable iff (!rst_b_in)
    mode_in == 2'h0 && !clk_out_en_in |-> tx_fall_out == tx_rise_out) else $error("fall bit not rise bit");
endmodule

bind lvds_tx_serializer lvds_tx_checker lvds_tx_checker_i (.sys_clk_in, .rst_b_in, .fast_clk_in, .word_valid_in,
  .factor_in, .mode_in, .clk_out_en_in, .phase_step_in, .word_ready_out, .cfg_err_out, .pll_phase_sel_out,
  .tx_rise_out, .tx_fall_out);

/* verif/lvds_tx_serializer_bench.sv */
/*
  Self-checking bench for one transmitter channel, serial and bypass paths.
  Assumes the receiver model beside it and a fresh reset for every configuration.
*/
`timescale 1ns/1ps
module lvds_tx_serializer_bench;
  logic        sys_clk_in, rst_b_in, fast_clk_in, word_valid_in, lane_pick_in, clk_out_en_in, phase_180_in;
  logic [9:0]  par_word_in, w;
  logic [95:0] lane_bus_in;
  logic [3:0]  lane_sel_in, factor_in, clk_div_in;
  logic [1:0]  mode_in;
  logic [2:0]  phase_step_in, pll_phase_sel_out;
  logic        word_ready_out, cfg_err_out, tx_rise_out, tx_fall_out, done, fall_seen;
  logic [19:0] cap;
  int          bad_count, cmp_count, cyc;

  lvds_tx_serializer lvds_tx_serializer_i (.sys_clk_in, .rst_b_in, .fast_clk_in, .word_valid_in, .par_word_in,
    .lane_bus_in, .lane_sel_in, .lane_pick_in, .factor_in, .mode_in, .clk_out_en_in, .clk_div_in, .phase_180_in,
    .phase_step_in, .word_ready_out, .cfg_err_out, .pll_phase_sel_out, .tx_rise_out, .tx_fall_out);
  serial_rx_model serial_rx_model_i (.fast_clk_in, .rst_b_in, .rise_in(tx_rise_out), .fall_in(tx_fall_out),
    .cap_out(cap), .done_out(done), .fall_seen_out(fall_seen));

  // ==========================================================================
  // clocks, unrelated in phase
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    fast_clk_in = 1'b0;
    #7;
    forever #24 fast_clk_in = ~fast_clk_in;
  end

  // ==========================================================================
  // checking helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // twenty bits of a repeating f-bit word, msb first
  function automatic logic [19:0] rep(input logic [9:0] wd, input int f);
    logic [19:0] r;
    for (int i = 0; i < 20; i++)
      r[19 - i] = wd[f - 1 - (i % f)];
    return r;
  endfunction

  // word held until the edge that sees ready high
  task automatic send_word(input logic [9:0] wd);
    @(posedge sys_clk_in);
    word_valid_in <= 1'b1;
    par_word_in   <= wd;
    for (int k = 0; k < 100; k++) begin
      @(posedge sys_clk_in);
      if (word_ready_out === 1'b1)
        break;
    end
    word_valid_in <= 1'b0;
  endtask

  // config changed only under reset, since it crosses bit by bit
  task automatic run(input logic [1:0] m, input logic [3:0] f, input logic [3:0] d, input logic ce,
                     input logic p, input logic e, input logic [9:0] wd, input logic [19:0] x);
    @(posedge sys_clk_in);
    rst_b_in <= 1'b0;
    @(posedge sys_clk_in);
    mode_in       <= m;
    factor_in     <= f;
    clk_div_in    <= d;
    clk_out_en_in <= ce;
    phase_180_in  <= p;
    phase_step_in <= f[2:0];
    repeat (10) @(posedge sys_clk_in);
    chk({word_ready_out, cfg_err_out, tx_rise_out, tx_fall_out, pll_phase_sel_out}, 20'h00040);
    rst_b_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    chk({cfg_err_out, pll_phase_sel_out}, {e, f[2:0]});
    send_word(wd);
    for (int k = 0; k < 400 && done !== 1'b1; k++)
      @(posedge sys_clk_in);
    chk(cap, x);
    if (m != 2'h0 || (ce && x == 20'hFFFFF))
      chk(fall_seen, (m != 2'h0) ? wd[0] : 1'b0);
  endtask

  // ==========================================================================
  // hang guard, well above the twenty short runs
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      report_and_stop();
    end
  end

  // ==========================================================================
  // test sequence
  initial begin
    rst_b_in = 1'b0;
    word_valid_in = 1'b0;
    par_word_in = 10'h000;
    lane_bus_in = {8'hA5, 80'h0, 8'h93};
    lane_sel_in = 4'hC;
    lane_pick_in = 1'b0;
    factor_in = 4'h8;
    mode_in = 2'h0;
    clk_out_en_in = 1'b0;
    clk_div_in = 4'h1;
    phase_180_in = 1'b0;
    phase_step_in = 3'h0;
    for (int f = 3; f <= 10; f++) begin
      w = 10'((10'h2B5 | (10'h001 << (f - 1))) & ((10'h001 << f) - 10'h001));
      run(2'h0, 4'(f), 4'h1, 1'b0, 1'b0, 1'b0, w, rep(w, f));
    end
    lane_pick_in <= 1'b1;
    run(2'h0, 4'h8, 4'h1, 1'b0, 1'b0, 1'b0, 10'h000, rep(10'h0A5, 8));
    lane_sel_in <= 4'h1;
    run(2'h0, 4'h8, 4'h1, 1'b0, 1'b0, 1'b0, 10'h000, rep(10'h093, 8));
    lane_pick_in <= 1'b0;
    run(2'h0, 4'h8, 4'h2, 1'b1, 1'b0, 1'b0, 10'h000, rep(10'h0AA, 8));
    run(2'h0, 4'h8, 4'h8, 1'b1, 1'b1, 1'b0, 10'h000, rep(10'h0F0, 8));
    run(2'h0, 4'h6, 4'h6, 1'b1, 1'b0, 1'b0, 10'h000, rep(10'h038, 6));
    run(2'h0, 4'hA, 4'hA, 1'b1, 1'b0, 1'b0, 10'h000, rep(10'h3E0, 10));
    run(2'h0, 4'h4, 4'h1, 1'b1, 1'b0, 1'b0, 10'h000, 20'hFFFFF);
    run(2'h0, 4'h6, 4'h4, 1'b1, 1'b0, 1'b1, 10'h000, 20'hFFFFF);
    run(2'h3, 4'h4, 4'h1, 1'b0, 1'b0, 1'b1, 10'h009, rep(10'h009, 4));
    run(2'h0, 4'h2, 4'h1, 1'b0, 1'b0, 1'b1, 10'h2B5, rep(10'h2B5, 10));
    run(2'h2, 4'h8, 4'h1, 1'b0, 1'b0, 1'b0, 10'h002, 20'hFFFFF);
    run(2'h1, 4'h8, 4'h1, 1'b0, 1'b0, 1'b0, 10'h001, 20'hFFFFF);
    report_and_stop();
  end
endmodule

/* verif/serial_rx_model.sv */
/*
  Downstream serial receiver: collects twenty rise bits from the first high bit.
  Assumes words are sent with their msb set, so the first high bit marks a word edge.
*/
`timescale 1ns/1ps
module serial_rx_model (
  input  wire logic        fast_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        rise_in,
  input  wire logic        fall_in,
  output logic      [19:0] cap_out,
  output logic             done_out,
  output logic             fall_seen_out
);
  logic [4:0] cnt_ff;

  // ==========================================================================
  // one bit a fast cycle; the word edge is not visible on the wire
  always_ff @(posedge fast_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_ff  <= 5'h00;
      cap_out <= 20'h00000;
    end else if ((cnt_ff != 5'h00 || rise_in) && cnt_ff < 5'h14) begin
      cnt_ff  <= cnt_ff + 5'h01;
      cap_out <= {cap_out[18:0], rise_in};
    end
  end

  // fall bit read half a cycle after launch
  always_ff @(posedge fast_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      fall_seen_out <= 1'b0;
    else
      fall_seen_out <= fall_in;
  end

  assign done_out = (cnt_ff == 5'h14);
endmodule
